/* core/dram_rank_pair.sv */
// Purpose: device end: two ranks with power states, command gating,
//    termination and a small masked word store
// Assumes: link pins arrive asynchronously and are filtered by three flops
// Notes: one data beat per read or write; column bits 3:0 index the store
`timescale 1ns/1ns
module dram_rank_pair import dram_pin_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // link pins
   dram_link_if.mem link,
   // status per rank
   output logic [RANKS-1:0] term_active,
   output logic [RANKS-1:0] in_power_down,
   output logic [RANKS-1:0] in_self_refresh
);
   typedef struct packed {
      logic ck;
      logic [RANKS-1:0] cke;
      logic [RANKS-1:0] cs_n;
      logic [2:0] cmd;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic [RANKS-1:0] term;
      logic [DQ_W-1:0] dq;
      logic lstb;
      logic ustb;
      logic lmask;
      logic umask;
   } link_in_t;

   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_HIGH, RD_LOW} rd_t;

   typedef struct packed {
      link_in_t s1;
      link_in_t s2;
      link_in_t s3;
      link_in_t lvl;
      pwr_t [RANKS-1:0] pwr;
      logic [RANKS-1:0][BANKS-1:0] open;
      logic [RANKS-1:0] term_en;
      logic [RANKS-1:0] term_reg;
      logic [RANKS-1:0] term_out;
      logic [RANKS-1:0] pd;
      logic [RANKS-1:0] sr;
      logic [RANKS-1:0][MEM_WORDS-1:0][DQ_W-1:0] mem;
      logic [1:0] wr_pend;
      logic wr_rank;
      logic [MEM_AW-1:0] wr_idx;
      rd_t rd;
      logic rd_rank;
      logic [MEM_AW-1:0] rd_idx;
      logic [DQ_W-1:0] dq_out;
      logic dq_oe_n;
      logic lstb;
      logic ustb;
   } state_t;

   state_t q;
   state_t next_q;
   link_in_t raw;
   logic rst_n;
   logic ck_rise;
   logic ck_fall;
   logic lstb_rise;
   logic ustb_rise;

   // pin reset and core reset both act without the clock
   assign rst_n = arst_n & link.reset_n;

   // gather the pins into one vector for the filter
   assign raw = '{ck: link.ck, cke: link.cke, cs_n: link.cs_n,
      cmd: {link.ras_n, link.cas_n, link.we_n}, ba: link.ba, addr: link.addr,
      term: link.termination_control, dq: link.dq, lstb: link.lower_byte_strobe,
      ustb: link.upper_byte_strobe, lmask: link.lower_byte_write_mask,
      umask: link.upper_byte_write_mask};

   // next state of the whole device
   always_comb begin
      next_q = q;
      next_q.s1 = raw;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      // a bit changes only once stages two and three agree
      next_q.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
      ck_rise = next_q.lvl.ck & !q.lvl.ck;
      ck_fall = !next_q.lvl.ck & q.lvl.ck;
      lstb_rise = next_q.lvl.lstb & !q.lvl.lstb;
      ustb_rise = next_q.lvl.ustb & !q.lvl.ustb;
      for (int r = 0; r < RANKS; r++) begin
         if (q.pwr[r] == PWR_SELF_REF) begin
            // no clock qualifies the exit; other pins are ignored here
            if (next_q.lvl.cke[r]) begin
               next_q.pwr[r] = PWR_ON;
            end
         end else if (ck_rise) begin
            if (q.pwr[r] != PWR_ON) begin
               // commands are dropped while powered down
               if (next_q.lvl.cke[r]) begin
                  next_q.pwr[r] = PWR_ON;
               end
            end else if (!next_q.lvl.cke[r]) begin
               if (q.open[r] != '0) begin
                  next_q.pwr[r] = PWR_ACT_PD;
               end else if (!next_q.lvl.cs_n[r] && next_q.lvl.cmd == CMD_REF) begin
                  next_q.pwr[r] = PWR_SELF_REF;
               end else begin
                  next_q.pwr[r] = PWR_PRE_PD;
               end
            end else if (!next_q.lvl.cs_n[r]) begin
               // select and the three command lines from one sample
               case (next_q.lvl.cmd)
                  CMD_ACT: begin
                     next_q.open[r][next_q.lvl.ba] = 1'b1;
                  end
                  CMD_PRE: begin
                     if (next_q.lvl.addr[ALL_BANK_BIT]) begin
                        next_q.open[r] = '0;
                     end else begin
                        next_q.open[r][next_q.lvl.ba] = 1'b0;
                     end
                  end
                  CMD_MRS: begin
                     if (next_q.lvl.ba == MR_TERM) begin
                        next_q.term_en[r] = next_q.lvl.addr[TERM_EN_BIT];
                     end
                  end
                  CMD_WR: begin
                     next_q.wr_pend = 2'h3;
                     next_q.wr_rank = 1'(r);
                     next_q.wr_idx = next_q.lvl.addr[MEM_AW-1:0];
                  end
                  CMD_RD: begin
                     if (q.rd == RD_IDLE) begin
                        next_q.rd = RD_WAIT;
                        next_q.rd_rank = 1'(r);
                        next_q.rd_idx = next_q.lvl.addr[MEM_AW-1:0];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         // termination pin still watched in power-down, not in self refresh
         if (ck_rise && q.pwr[r] != PWR_SELF_REF) begin
            next_q.term_reg[r] = next_q.lvl.term[r];
         end
         // applies to data, strobes and masks only; off when mode disables it
         next_q.term_out[r] = next_q.term_en[r] & next_q.term_reg[r] &
            (next_q.pwr[r] != PWR_SELF_REF);
         next_q.pd[r] = (next_q.pwr[r] == PWR_PRE_PD) || (next_q.pwr[r] == PWR_ACT_PD);
         next_q.sr[r] = next_q.pwr[r] == PWR_SELF_REF;
      end
      // write beat: data is stable half a link period before the strobe rises
      if (q.wr_pend[0] && lstb_rise) begin
         next_q.wr_pend[0] = 1'b0;
         if (!next_q.lvl.lmask) begin
            next_q.mem[q.wr_rank][q.wr_idx][BYTE_W-1:0] =
               next_q.lvl.dq[BYTE_W-1:0];
         end
      end
      if (q.wr_pend[1] && ustb_rise) begin
         next_q.wr_pend[1] = 1'b0;
         if (!next_q.lvl.umask) begin
            next_q.mem[q.wr_rank][q.wr_idx][DQ_W-1:BYTE_W] =
               next_q.lvl.dq[DQ_W-1:BYTE_W];
         end
      end
      // read beat: data and strobes leave together on a clock rise
      case (q.rd)
         RD_WAIT: begin
            if (ck_rise) begin
               next_q.dq_out = q.mem[q.rd_rank][q.rd_idx];
               next_q.dq_oe_n = 1'b0;
               next_q.lstb = 1'b1;
               next_q.ustb = 1'b1;
               next_q.rd = RD_HIGH;
            end
         end
         RD_HIGH: begin
            if (ck_fall) begin
               next_q.lstb = 1'b0;
               next_q.ustb = 1'b0;
               next_q.rd = RD_LOW;
            end
         end
         RD_LOW: begin
            // data held past the strobe fall so the far end can take it there
            if (ck_rise) begin
               next_q.dq_oe_n = 1'b1;
               next_q.rd = RD_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // single state register, frozen while clk_en is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.term_en <= {RANKS{TERM_EN_RST}};
         q.dq_oe_n <= 1'b1;
      end else if (clk_en) begin
         q <= next_q;
      end
   end

   // outputs straight from the state register
   assign term_active = q.term_out;
   assign in_power_down = q.pd;
   assign in_self_refresh = q.sr;
   assign link.mem_dq = q.dq_out;
   assign link.mem_data_oe_n = q.dq_oe_n;
   assign link.mem_lower_byte_strobe = q.lstb;
   assign link.mem_upper_byte_strobe = q.ustb;
endmodule // dram_rank_pair

/* core/dram_pin_pkg.sv */
// Purpose: shared constants and types for the two-rank dram pin link
// Assumes: core_clk at 100 MHz on both ends
// Notes: command code is {row strobe, column strobe, write enable}, all low-true
package dram_pin_pkg;
   localparam int RANKS = 2;
   localparam int BANKS = 8;
   localparam int DQ_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 15;
   localparam int BA_W = 3;
   localparam int MEM_AW = 4;
   localparam int MEM_WORDS = 16;
   localparam int BUF_DEPTH = 2;
   // link clock made by the controller's divider
   localparam int CLK_NS = 10;
   localparam int CK_PERIOD_NS = 160;
   localparam int CK_HALF = CK_PERIOD_NS / (2 * CLK_NS);
   localparam logic [3:0] CK_HALF_M1 = 4'(CK_HALF - 1);
   // command codes
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // mode register holding the termination enable
   localparam logic [BA_W-1:0] MR_TERM = 3'h1;
   localparam int TERM_EN_BIT = 2;
   localparam int ALL_BANK_BIT = 10;
   localparam logic TERM_EN_RST = 1'h1;
   typedef enum logic [3:0] {
      OP_ACT, OP_PRE, OP_RD, OP_WR, OP_REF, OP_MRS, OP_PDE, OP_PDX, OP_SRE, OP_SRX
   } user_op_t;
   typedef enum logic [1:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} pwr_t;
endpackage

/* core/dram_link_if.sv */
// Purpose: pins between memory controller and two-rank dram
// Assumes: one enable per side covers the data byte lanes and both strobes
// Notes: an undriven data group reads as zero
`timescale 1ns/1ns
interface dram_link_if import dram_pin_pkg::*; ();
   logic ck;
   logic reset_n;
   logic [RANKS-1:0] cke;
   logic [RANKS-1:0] cs_n;
   logic [RANKS-1:0] termination_control;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic lower_byte_write_mask;
   logic upper_byte_write_mask;
   logic [DQ_W-1:0] mc_dq;
   logic mc_lower_byte_strobe;
   logic mc_upper_byte_strobe;
   logic mc_data_oe_n;
   logic [DQ_W-1:0] mem_dq;
   logic mem_lower_byte_strobe;
   logic mem_upper_byte_strobe;
   logic mem_data_oe_n;
   logic [DQ_W-1:0] dq;
   logic lower_byte_strobe;
   logic upper_byte_strobe;
   // wire level from the enables; controller wins a clash
   assign dq = !mc_data_oe_n ? mc_dq : (!mem_data_oe_n ? mem_dq : '0);
   assign lower_byte_strobe = !mc_data_oe_n ? mc_lower_byte_strobe :
      (!mem_data_oe_n && mem_lower_byte_strobe);
   assign upper_byte_strobe = !mc_data_oe_n ? mc_upper_byte_strobe :
      (!mem_data_oe_n && mem_upper_byte_strobe);
   modport mc (output ck, reset_n, cke, cs_n, termination_control, ras_n, cas_n, we_n,
      ba, addr, lower_byte_write_mask, upper_byte_write_mask, mc_dq,
      mc_lower_byte_strobe, mc_upper_byte_strobe, mc_data_oe_n,
      input dq, lower_byte_strobe, upper_byte_strobe);
   modport mem (input ck, reset_n, cke, cs_n, termination_control, ras_n, cas_n, we_n,
      ba, addr, lower_byte_write_mask, upper_byte_write_mask, dq,
      lower_byte_strobe, upper_byte_strobe,
      output mem_dq, mem_lower_byte_strobe, mem_upper_byte_strobe, mem_data_oe_n);
endinterface

/* core/dram_link_master.sv */
// Purpose: controller end: one user request becomes one link command
// Assumes: the device end answers a read one link clock after the command
// Notes: link clock made here by a divider; read data waits in two entries
`timescale 1ns/1ns
module dram_link_master import dram_pin_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // requests
   input wire logic req_valid,
   output logic req_ready,
   input wire user_op_t req_op,
   input wire logic req_rank,
   input wire logic [BA_W-1:0] req_bank,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DQ_W-1:0] req_wdata,
   input wire logic [1:0] req_wmask,
   input wire logic [RANKS-1:0] term_req,
   // read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [DQ_W-1:0] rd_data,
   // link pins
   dram_link_if.mc link
);
   typedef enum logic [2:0] {C_IDLE, C_ISSUE, C_HOLD, C_WBEAT, C_RBEAT} mc_t;
   typedef struct packed {
      logic [DQ_W-1:0] dq;
      logic lstb;
      logic ustb;
   } back_t;
   typedef struct packed {
      logic [3:0] div;
      logic ck;
      logic rst_pin;
      back_t s1;
      back_t s2;
      back_t s3;
      back_t lvl;
      mc_t st;
      user_op_t op;
      logic rank;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] wdata;
      logic [1:0] wmask;
      logic [RANKS-1:0] cke;
      logic [RANKS-1:0] cs_n;
      logic [RANKS-1:0] term;
      logic [2:0] cmd;
      logic [DQ_W-1:0] dq_out;
      logic oe_n;
      logic lstb;
      logic ustb;
      logic lm;
      logic um;
      logic [BUF_DEPTH-1:0][DQ_W-1:0] buffer;
      logic [1:0] cnt;
      logic ready;
      logic valid;
   } state_t;

   state_t q;
   state_t next_q;
   logic tick;
   logic fall_ev;
   logic rise_ev;

   // link command code for a user operation
   function automatic logic [2:0] op_cmd(input user_op_t op);
      case (op)
         OP_ACT: op_cmd = CMD_ACT;
         OP_PRE: op_cmd = CMD_PRE;
         OP_RD: op_cmd = CMD_RD;
         OP_WR: op_cmd = CMD_WR;
         OP_REF, OP_SRE: op_cmd = CMD_REF;
         OP_MRS: op_cmd = CMD_MRS;
         default: op_cmd = CMD_NOP;
      endcase
   endfunction

   // next state of the whole controller
   always_comb begin
      next_q = q;
      next_q.rst_pin = 1'b1;
      tick = q.div == CK_HALF_M1;
      next_q.div = tick ? 4'h0 : q.div + 4'h1;
      next_q.ck = tick ? !q.ck : q.ck;
      fall_ev = tick & q.ck;
      rise_ev = tick & !q.ck;
      next_q.s1 = '{dq: link.dq, lstb: link.lower_byte_strobe, ustb: link.upper_byte_strobe};
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
      // pop before push so a full buffer can turn over in one cycle
      if (q.valid && rd_ready) begin
         next_q.buffer[0] = q.buffer[1];
         next_q.cnt = q.cnt - 2'h1;
      end
      // pins change at the link clock fall, a half period before sampling
      if (fall_ev) begin
         next_q.term = term_req;
      end
      case (q.st)
         C_IDLE: begin
            if (q.ready && req_valid) begin
               next_q.op = req_op;
               next_q.rank = req_rank;
               next_q.ba = req_bank;
               next_q.addr = req_addr;
               next_q.wdata = req_wdata;
               next_q.wmask = req_wmask;
               next_q.st = C_ISSUE;
            end
         end
         C_ISSUE: begin
            if (fall_ev) begin
               next_q.cmd = op_cmd(q.op);
               next_q.ba = q.ba;
               if (next_q.cmd != CMD_NOP) begin
                  next_q.cs_n[q.rank] = 1'b0;
               end
               if (q.op == OP_PDE || q.op == OP_SRE) begin
                  next_q.cke[q.rank] = 1'b0;
               end
               if (q.op == OP_PDX || q.op == OP_SRX) begin
                  next_q.cke[q.rank] = 1'b1;
               end
               next_q.st = C_HOLD;
            end
         end
         C_HOLD: begin
            if (fall_ev) begin
               next_q.cs_n = '1;
               next_q.cmd = CMD_NOP;
               next_q.st = C_IDLE;
               if (q.op == OP_WR) begin
                  next_q.dq_out = q.wdata;
                  next_q.oe_n = 1'b0;
                  next_q.lm = q.wmask[0];
                  next_q.um = q.wmask[1];
                  next_q.st = C_WBEAT;
               end else if (q.op == OP_RD) begin
                  next_q.st = C_RBEAT;
               end
            end
         end
         C_WBEAT: begin
            // strobe rises mid-beat, centred on the write data
            if (rise_ev) begin
               next_q.lstb = 1'b1;
               next_q.ustb = 1'b1;
            end else if (fall_ev && q.lstb) begin
               next_q.lstb = 1'b0;
               next_q.ustb = 1'b0;
               next_q.oe_n = 1'b1;
               next_q.lm = 1'b0;
               next_q.um = 1'b0;
               next_q.st = C_IDLE;
            end
         end
         default: begin
            // edge-aligned read: take the word at the strobe fall
            if (!next_q.lvl.lstb && q.lvl.lstb) begin
               next_q.buffer[next_q.cnt[0]] = next_q.lvl.dq;
               next_q.cnt = next_q.cnt + 2'h1;
               next_q.st = C_IDLE;
            end
         end
      endcase
      // ready holds back while the read buffer has no free entry
      next_q.ready = (next_q.st == C_IDLE) && (next_q.cnt < 2'(BUF_DEPTH));
      next_q.valid = next_q.cnt != 2'h0;
   end

   // single state register, frozen while clk_en is low
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.cke <= '1;
         q.cs_n <= '1;
         q.cmd <= CMD_NOP;
         q.oe_n <= 1'b1;
      end else if (clk_en) begin
         q <= next_q;
      end
   end

   // outputs straight from the state register
   assign req_ready = q.ready;
   assign rd_valid = q.valid;
   assign rd_data = q.buffer[0];
   assign link.ck = q.ck;
   assign link.reset_n = q.rst_pin;
   assign link.cke = q.cke;
   assign link.cs_n = q.cs_n;
   assign link.termination_control = q.term;
   assign {link.ras_n, link.cas_n, link.we_n} = q.cmd;
   assign link.ba = q.ba;
   assign link.addr = q.addr;
   assign link.lower_byte_write_mask = q.lm;
   assign link.upper_byte_write_mask = q.um;
   assign link.mc_dq = q.dq_out;
   assign link.mc_data_oe_n = q.oe_n;
   assign link.mc_lower_byte_strobe = q.lstb;
   assign link.mc_upper_byte_strobe = q.ustb;
endmodule // dram_link_master

/* sim/dram_pin_link_monitor.sv */
// Purpose: wire checks on the link between controller and two-rank device
// Assumes: controller pins change at its link clock fall, clock made by a divider of 16 (eight core cycles per phase)
// Notes: instantiated beside the interface, no bind
`timescale 1ns/1ns
module dram_pin_link_monitor import dram_pin_pkg::*; (
   // clock and reset
   input logic core_clk,
   input logic arst_n,
   // controller pins
   input logic ck,
   input logic [RANKS-1:0] cke,
   input logic [RANKS-1:0] cs_n,
   input logic [RANKS-1:0] termination_control,
   input logic ras_n,
   input logic cas_n,
   input logic we_n,
   input logic lower_byte_write_mask,
   input logic upper_byte_write_mask,
   input logic [DQ_W-1:0] mc_dq,
   input logic mc_lower_byte_strobe,
   input logic mc_upper_byte_strobe,
   input logic mc_data_oe_n,
   // device pins
   input logic mem_lower_byte_strobe,
   input logic mem_data_oe_n
);
   // one domain only, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_ck_half_period: assert property ($rose(ck) |-> ck [*8] ##1 !ck)
      else $error("link clock high phase is not eight cycles");
   a_cmd_at_fall: assert property ($changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(ck))
      else $error("command lines moved away from a link clock fall");
   a_cke_at_fall: assert property ($changed(cke) |-> $fell(ck))
      else $error("clock enable moved away from a link clock fall");
   a_term_at_fall: assert property ($changed(termination_control) |-> $fell(ck))
      else $error("termination control moved away from a link clock fall");
   a_one_rank: assert property (cs_n != 2'h0)
      else $error("both ranks selected at once");
   a_nop_deselect: assert property (cs_n == 2'h3 |-> {ras_n, cas_n, we_n} == CMD_NOP)
      else $error("command code without a selected rank");
   a_mask_with_data: assert property ((lower_byte_write_mask || upper_byte_write_mask)
      |-> !mc_data_oe_n)
      else $error("write mask raised without write data");
   a_wdata_held: assert property (mc_lower_byte_strobe |-> $stable(mc_dq) && !mc_data_oe_n
      && mc_upper_byte_strobe)
      else $error("write data moved while the strobes were high");
   a_strobe_centred: assert property ($fell(mc_data_oe_n)
      |-> !mc_lower_byte_strobe [*8] ##1 mc_lower_byte_strobe)
      else $error("write strobe not in the middle of the beat");
   a_read_aligned: assert property ($rose(mem_lower_byte_strobe) |-> $fell(mem_data_oe_n)
      && mc_data_oe_n)
      else $error("read strobe not aligned with read data");
endmodule // dram_pin_link_monitor

/* sim/dual_rank_dram_pin_control_tb.sv */
// Purpose: both ends joined, user side driven with random data and stalls
// Assumes: requests are taken on valid and ready, one link command each
// Notes: status flags need a few link periods through the device's pin filter
`timescale 1ns/1ns
module dual_rank_dram_pin_control_tb import dram_pin_pkg::*;;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   user_op_t req_op = OP_ACT;
   logic req_rank = 1'b0;
   logic [BA_W-1:0] req_bank = '0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DQ_W-1:0] req_wdata = '0;
   logic [1:0] req_wmask = '0;
   logic [RANKS-1:0] term_req = '0;
   logic rd_valid;
   logic rd_ready = 1'b0;
   logic [DQ_W-1:0] rd_data;
   logic [RANKS-1:0] term_active, in_power_down, in_self_refresh;
   logic [RANKS-1:0] asleep = '0;
   logic hold_rd = 1'b0;
   logic [31:0] seed = 32'hfc76fb9c;
   logic [DQ_W-1:0] exp_q[$];
   logic [DQ_W-1:0] mem_m [RANKS][MEM_WORDS];
   int n_mismatch = 0;
   int compares = 0;

   dram_link_if link ();
   dram_link_master dram_link_master_inst (.core_clk(core_clk), .arst_n(arst_n),
      .clk_en(1'b1), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_rank(req_rank), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_wmask(req_wmask), .term_req(term_req), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .link(link));
   dram_rank_pair dram_rank_pair_inst (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
      .link(link), .term_active(term_active), .in_power_down(in_power_down),
      .in_self_refresh(in_self_refresh));
   dram_pin_link_monitor dram_pin_link_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
      .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n),
      .termination_control(link.termination_control), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .lower_byte_write_mask(link.lower_byte_write_mask),
      .upper_byte_write_mask(link.upper_byte_write_mask), .mc_dq(link.mc_dq),
      .mc_lower_byte_strobe(link.mc_lower_byte_strobe),
      .mc_upper_byte_strobe(link.mc_upper_byte_strobe), .mc_data_oe_n(link.mc_data_oe_n),
      .mem_lower_byte_strobe(link.mem_lower_byte_strobe), .mem_data_oe_n(link.mem_data_oe_n));

   always #(CLK_NS / 2) core_clk = ~core_clk;

   function automatic logic [31:0] xs(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic end_of_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp_data(logic [DQ_W-1:0] got, logic [DQ_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flags(logic [RANKS-1:0] got, logic [RANKS-1:0] exp);
      cmp_data({14'h0, got}, {14'h0, exp});
   endtask

   // bounded wait for the controller to take requests, then k quiet cycles
   task automatic idle(int k);
      int n;
      n = 0;
      @(posedge core_clk);
      while (req_ready !== 1'b1) begin
         @(posedge core_clk);
         n++;
         if (n > 3000) begin
            n_mismatch++;
            end_of_test();
         end
      end
      repeat (k) @(posedge core_clk);
   endtask

   // one request; the model only changes for a rank that is awake
   task automatic req(user_op_t op, logic rk, logic [BA_W-1:0] b, logic [ADDR_W-1:0] a,
      logic [1:0] m);
      idle(0);
      if (op == OP_WR && !asleep[rk]) begin
         if (!m[0]) mem_m[rk][a[3:0]][7:0] = seed[7:0];
         if (!m[1]) mem_m[rk][a[3:0]][15:8] = seed[15:8];
      end
      if (op == OP_RD) exp_q.push_back(mem_m[rk][a[3:0]]);
      req_op <= op;
      req_rank <= rk;
      req_bank <= b;
      req_addr <= a;
      req_wdata <= seed[DQ_W-1:0];
      req_wmask <= m;
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
   endtask

   // random stalls of the read side; hold_rd stops it to fill the buffer
   always @(posedge core_clk) begin
      seed <= xs(seed);
      rd_ready <= !hold_rd && seed[0];
   end

   // every read word is checked against the oldest note
   always @(posedge core_clk) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         cmp_data(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
   end

   initial begin
      foreach (mem_m[r, w]) mem_m[r][w] = '0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      // open a row in both ranks, then plain, lower and upper masked writes
      req(OP_ACT, 1'b0, 3'h2, 15'h0, 2'h0);
      req(OP_ACT, 1'b1, 3'h2, 15'h0, 2'h0);
      for (int i = 0; i < 8; i++) begin
         req(OP_WR, i[0], 3'h2, 15'h5, i[2:1]);
         req(OP_RD, i[0], 3'h2, 15'h5, 2'h0);
         req(OP_RD, !i[0], 3'h2, 15'h5, 2'h0);
      end
      // termination per rank, then disabled by the mode load for rank 0
      term_req <= 2'h1;
      idle(40);
      cmp_flags(term_active, 2'h1);
      term_req <= 2'h2;
      idle(40);
      cmp_flags(term_active, 2'h2);
      req(OP_MRS, 1'b0, MR_TERM, 15'h0, 2'h0);
      term_req <= 2'h3;
      idle(40);
      cmp_flags(term_active, 2'h2);
      req(OP_MRS, 1'b0, MR_TERM, 15'h4, 2'h0);
      req(OP_REF, 1'b0, 3'h0, 15'h0, 2'h0);
      // precharge power-down on rank 0, active power-down on rank 1
      req(OP_PRE, 1'b0, 3'h2, 15'h0, 2'h0);
      req(OP_PDE, 1'b0, 3'h0, 15'h0, 2'h0);
      idle(40);
      cmp_flags(in_power_down, 2'h1);
      asleep = 2'h1;
      req(OP_WR, 1'b0, 3'h2, 15'h5, 2'h0);
      req(OP_PDX, 1'b0, 3'h0, 15'h0, 2'h0);
      req(OP_PDE, 1'b1, 3'h0, 15'h0, 2'h0);
      idle(40);
      cmp_flags(in_power_down, 2'h2);
      asleep = 2'h0;
      req(OP_PDX, 1'b1, 3'h0, 15'h0, 2'h0);
      req(OP_RD, 1'b0, 3'h2, 15'h5, 2'h0);
      // self refresh on rank 1 drops a write, leaves on enable alone
      req(OP_PRE, 1'b1, 3'h0, 15'h400, 2'h0);
      req(OP_SRE, 1'b1, 3'h0, 15'h0, 2'h0);
      idle(40);
      cmp_flags(in_self_refresh, 2'h2);
      asleep = 2'h2;
      req(OP_WR, 1'b1, 3'h2, 15'h5, 2'h0);
      asleep = 2'h0;
      req(OP_SRX, 1'b1, 3'h0, 15'h0, 2'h0);
      idle(40);
      cmp_flags(in_self_refresh, 2'h0);
      // fill the read buffer with the reader stalled; no word may be lost
      hold_rd <= 1'b1;
      req(OP_RD, 1'b1, 3'h2, 15'h5, 2'h0);
      req(OP_RD, 1'b0, 3'h2, 15'h5, 2'h0);
      repeat (200) @(posedge core_clk);
      hold_rd <= 1'b0;
      for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge core_clk);
      if (exp_q.size() > 0) n_mismatch++;
      cmp_flags(term_active, 2'h3);
      // reset taken mid-cycle: flags must clear before the next clock rise
      arst_n <= 1'h0;
      @(negedge core_clk);
      cmp_flags(term_active, 2'h0);
      end_of_test();
   end

   // a hang counts as a failure
   initial begin
      #(40000 * CLK_NS);
      n_mismatch++;
      end_of_test();
   end
endmodule // dual_rank_dram_pin_control_tb
